// ==== amot_regs.sv ====
// Alarm mask, lane buffer fault flags and converter offset trim registers.
// Assumes event inputs, fuse words and calibration state are on clk_sys.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module amot_regs (
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire amot_pkg::amot_bus_req_t   bus_req,
	output logic [15:0]                    rd_data_q,
	input  wire logic [7:0]                lane_fifo_err,
	input  wire logic                      serdes_pll_unlock_flag,
	input  wire logic                      link_down_flag,
	input  wire logic                      clock_realign_flag,
	input  wire logic                      divider_mismatch_flag,
	input  wire amot_pkg::amot_fuse_trim_t fuse_trim,
	input  wire amot_pkg::amot_cal_state_t cal_state,
	input  wire logic                      sample_input_b,
	output logic                           alarm_irq_q,
	output logic [11:0]                    core0_offset_q,
	output logic [11:0]                    core1_offset_q,
	output logic [11:0]                    core2_offset_q,
	output logic                           spare_fg_offset_cal_q
);
	import amot_pkg::*;

	// ********************************************************
	// Address decode
	// ********************************************************
	wire logic wr_status = bus_req.wr && bus_req.addr == OFF_ALARM_STATUS;
	wire logic wr_masks  = bus_req.wr && bus_req.addr == OFF_ALARM_MASKS;
	wire logic wr_lanes  = bus_req.wr && bus_req.addr == OFF_LANE_FAULTS;
	wire logic wr_core0  = bus_req.wr && bus_req.addr == OFF_CORE0_TRIM;
	wire logic wr_core1  = bus_req.wr && bus_req.addr == OFF_CORE1_TRIM;
	wire logic wr_core2a = bus_req.wr && bus_req.addr == OFF_CORE2_A_TRIM;
	wire logic wr_core2b = bus_req.wr && bus_req.addr == OFF_CORE2_B_TRIM;

	logic [7:0]  status_q;
	logic [7:0]  masks_q;
	logic [7:0]  lanes_q;
	logic [15:0] trim0_q;
	logic [15:0] trim1_q;
	logic [15:0] trim2a_q;
	logic [15:0] trim2b_q;
	logic        fuse_load_q;

	// ********************************************************
	// Alarm status, sticky with write-one-to-clear
	// ********************************************************
	wire logic [7:0] status_set = {2'b00,
		|lane_fifo_err,
		serdes_pll_unlock_flag,
		link_down_flag,
		clock_realign_flag,
		1'b0,
		divider_mismatch_flag};
	wire logic [7:0] status_clr = wr_status ? bus_req.wdata[7:0] : 8'h00;
	// Set wins over clear so an event in the clearing cycle survives.
	wire logic [7:0] status_d =
		(status_set | (status_q & ~status_clr)) & STATUS_STORED;

	// The lane buffer fault bit clear also wipes every lane flag.
	wire logic clear_all_lanes =
		wr_status && bus_req.wdata[BIT_LANE_BUFFER_FAULT];

	// ********************************************************
	// Summary alarm
	// ********************************************************
	wire logic summary_d =
		|(status_q & ~masks_q & ALARM_SRC_BITS);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_q    <= RST_ALARM_STATUS;
			masks_q     <= RST_ALARM_MASKS;
			alarm_irq_q <= 1'b0;
		end else begin
			status_q    <= status_d;
			// Reserved mask bits are kept as written by software.
			if (wr_masks)
				masks_q <= bus_req.wdata[7:0];
			alarm_irq_q <= summary_d;
		end
	end

	// ********************************************************
	// Per-lane buffer fault flags
	// ********************************************************
	logic [7:0] lanes_d;
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			wire logic clr = clear_all_lanes ||
				(wr_lanes && bus_req.wdata[gi]);
			// A fault in the clearing cycle wins, so no event is lost.
			assign lanes_d[gi] = lane_fifo_err[gi] ||
				(lanes_q[gi] && !clr);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			lanes_q <= RST_LANE_FAULTS;
		else
			lanes_q <= lanes_d;
	end

	// ********************************************************
	// Offset trims
	// ********************************************************
	// Trims are loaded from fuse storage on the first edge after reset
	// release; a write in that same cycle is dropped in favour of fuses.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fuse_load_q <= 1'b1;
			trim0_q     <= RST_TRIM;
			trim1_q     <= RST_TRIM;
			trim2a_q    <= RST_TRIM;
			trim2b_q    <= RST_TRIM;
		end else if (fuse_load_q) begin
			fuse_load_q <= 1'b0;
			trim0_q     <= {4'h0, fuse_trim.core0};
			trim1_q     <= {4'h0, fuse_trim.core1};
			trim2a_q    <= {4'h0, fuse_trim.core2_a};
			trim2b_q    <= {4'h0, fuse_trim.core2_b};
		end else begin
			if (wr_core0)
				trim0_q <= bus_req.wdata;
			if (wr_core1)
				trim1_q <= bus_req.wdata;
			if (wr_core2a)
				trim2a_q <= bus_req.wdata;
			if (wr_core2b)
				trim2b_q <= bus_req.wdata;
		end
	end

	// Only the low twelve bits reach the cores; bits 15:12 are storage.
	wire logic [11:0] core2_sel =
		sample_input_b ? trim2b_q[11:0] : trim2a_q[11:0];

	// ********************************************************
	// Calibration view
	// ********************************************************
	wire logic fg_restricted = cal_state.offset_cal_enable &&
		!(cal_state.background_cal_enable &&
		  cal_state.background_offset_cal_enable);
	wire logic bg_locked = cal_state.background_cal_enable &&
		cal_state.background_offset_cal_enable;
	// Advisory only: software is expected to honour this itself.
	wire logic trim_access_ok = !cal_state.offset_cal_busy && !bg_locked &&
		(!fg_restricted || cal_state.foreground_cal_done);
	wire logic spare_fg_d = cal_state.offset_cal_enable &&
		cal_state.background_cal_enable &&
		!cal_state.background_offset_cal_enable;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			core0_offset_q        <= 12'h000;
			core1_offset_q        <= 12'h000;
			core2_offset_q        <= 12'h000;
			spare_fg_offset_cal_q <= 1'b0;
		end else begin
			core0_offset_q        <= trim0_q[11:0];
			core1_offset_q        <= trim1_q[11:0];
			core2_offset_q        <= core2_sel;
			spare_fg_offset_cal_q <= spare_fg_d;
		end
	end

	// ********************************************************
	// Read path
	// ********************************************************
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		case (bus_req.addr)
			OFF_ALARM_SUMMARY: rd_mux = {15'h0000, alarm_irq_q};
			OFF_ALARM_STATUS:  rd_mux = {8'h00, status_q};
			OFF_ALARM_MASKS:   rd_mux = {8'h00, masks_q};
			OFF_LANE_FAULTS:   rd_mux = {8'h00, lanes_q};
			OFF_CAL_STATE:     rd_mux = {14'h0000, spare_fg_offset_cal_q,
				trim_access_ok};
			OFF_CORE0_TRIM:    rd_mux = trim0_q;
			OFF_CORE1_TRIM:    rd_mux = trim1_q;
			OFF_CORE2_A_TRIM:  rd_mux = trim2a_q;
			OFF_CORE2_B_TRIM:  rd_mux = trim2b_q;
			default:           rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= bus_req.rd ? rd_mux : 16'h0000;
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_lane_clear_write;
		wr_lanes && bus_req.wdata[0] && !lane_fifo_err[0];
	endsequence
	sequence s_lane_stays_clear;
		!lane_fifo_err[0];
	endsequence
	sequence s_spare_setup;
		cal_state.offset_cal_enable && cal_state.background_cal_enable &&
			!cal_state.background_offset_cal_enable;
	endsequence

	a_lane_sets: assert property (
		lane_fifo_err[3] |=> lanes_q[3])
		else $error("lane fault did not set its flag");
	a_lane_clears: assert property (
		s_lane_clear_write |=> !lanes_q[0])
		else $error("lane flag not cleared by write one");
	a_lane_clear_hold: assert property (
		s_lane_clear_write ##1 s_lane_stays_clear |=> !lanes_q[0])
		else $error("lane flag rose with no fault");
	a_all_lanes_wipe: assert property (
		clear_all_lanes && lane_fifo_err == 8'h00 |=> lanes_q == 8'h00)
		else $error("status bit 5 clear left lane flags");
	a_lane_reset_ones: assert property (
		$rose(resetn) |-> lanes_q == RST_LANE_FAULTS)
		else $error("lane flags not all ones after reset");
	a_mask_blocks: assert property (
		(masks_q & ALARM_SRC_BITS) == ALARM_SRC_BITS |=> !alarm_irq_q)
		else $error("masked source reached summary alarm");
	a_summary_follow: assert property (
		(status_q[BIT_LANE_BUFFER_FAULT] && !masks_q[BIT_LANE_BUFFER_FAULT]) ||
		(status_q[BIT_SERDES_PLL_UNLOCK] && !masks_q[BIT_SERDES_PLL_UNLOCK]) ||
		(status_q[BIT_LINK_DOWN] && !masks_q[BIT_LINK_DOWN]) ||
		(status_q[BIT_CLOCK_REALIGN] && !masks_q[BIT_CLOCK_REALIGN]) ||
		(status_q[BIT_DIVIDER_MISMATCH] && !masks_q[BIT_DIVIDER_MISMATCH])
		|=> alarm_irq_q)
		else $error("unmasked status did not raise alarm");
	a_fifo_status: assert property (
		|lane_fifo_err |=> status_q[BIT_LANE_BUFFER_FAULT])
		else $error("lane fault did not set status bit 5");
	a_core2_select: assert property (
		!fuse_load_q && sample_input_b
		|=> {4'h0, core2_offset_q} == ($past(trim2b_q) & 16'h0FFF))
		else $error("core 2 not using input B trim");
	a_trim_apply: assert property (
		wr_core0 && !fuse_load_q |=> ##1 core0_offset_q ==
			$past(bus_req.wdata[11:0], 2))
		else $error("core 0 offset not applied from trim");
	a_fuse_load: assert property (
		fuse_load_q |=> trim1_q[11:0] == $past(fuse_trim.core1))
		else $error("trim default not taken from fuses");

	// Each check below looks one edge past the cycle that triggers it.
	a_lane_no_fault: assert property (
		!lanes_q[2] && !lane_fifo_err[2] |=> !lanes_q[2])
		else $error("lane flag set with no fault");
	a_lane_set_wins: assert property (
		wr_lanes && bus_req.wdata[7] && lane_fifo_err[7] |=> lanes_q[7])
		else $error("lane fault lost in its clearing cycle");
	a_status_clear: assert property (
		wr_status && bus_req.wdata[BIT_LANE_BUFFER_FAULT] &&
		lane_fifo_err == 8'h00 |=> !status_q[BIT_LANE_BUFFER_FAULT])
		else $error("status bit 5 not cleared by write one");
	a_mask_store: assert property (
		wr_masks |=> {8'h00, masks_q} == ($past(bus_req.wdata) & 16'h00FF))
		else $error("mask write not stored");
	a_mask_link_down: assert property (
		masks_q[BIT_LINK_DOWN] && status_q == 8'h08 |=> !alarm_irq_q)
		else $error("masked link down reached summary alarm");
	a_core2_input_a: assert property (
		!sample_input_b
		|=> {4'h0, core2_offset_q} == ($past(trim2a_q) & 16'h0FFF))
		else $error("core 2 not using input A trim");
	a_trim_store: assert property (
		wr_core1 && !fuse_load_q |=> trim1_q == $past(bus_req.wdata))
		else $error("core 1 trim write not stored");
	a_spare_on: assert property (
		s_spare_setup |=> spare_fg_offset_cal_q)
		else $error("spare cores left out of foreground step");
	a_spare_off: assert property (
		!cal_state.offset_cal_enable |=> !spare_fg_offset_cal_q)
		else $error("spare foreground flag without offset cal");

endmodule : amot_regs

// ==== amot_pkg.sv ====
// Package for the alarm mask, lane fault and offset trim register bank.
// Assumes a 12-bit byte address register port with 16-bit data.
package amot_pkg;

	// ********************************************************
	// Bus and data widths
	// ********************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int LANES  = 8;
	localparam int TRIM_W = 12;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [11:0] OFF_ALARM_SUMMARY  = 12'h2C0;
	localparam logic [11:0] OFF_ALARM_STATUS   = 12'h2C1;
	localparam logic [11:0] OFF_ALARM_MASKS    = 12'h2C2;
	localparam logic [11:0] OFF_LANE_FAULTS    = 12'h2C4;
	localparam logic [11:0] OFF_CAL_STATE      = 12'h2C8;
	localparam logic [11:0] OFF_CORE0_TRIM     = 12'h330;
	localparam logic [11:0] OFF_CORE1_TRIM     = 12'h332;
	localparam logic [11:0] OFF_CORE2_A_TRIM   = 12'h334;
	localparam logic [11:0] OFF_CORE2_B_TRIM   = 12'h336;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int BIT_LANE_BUFFER_FAULT = 5;
	localparam int BIT_SERDES_PLL_UNLOCK = 4;
	localparam int BIT_LINK_DOWN         = 3;
	localparam int BIT_CLOCK_REALIGN     = 2;
	localparam int BIT_DIVIDER_MISMATCH  = 0;
	localparam logic [7:0] ALARM_SRC_BITS = 8'h3D;
	localparam logic [7:0] STATUS_STORED  = 8'h3F;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [7:0]  RST_ALARM_STATUS = 8'h3F;
	localparam logic [7:0]  RST_ALARM_MASKS  = 8'h3F;
	localparam logic [7:0]  RST_LANE_FAULTS  = 8'hFF;
	localparam logic [15:0] RST_TRIM         = 16'h0000;

	// ********************************************************
	// Carriers
	// ********************************************************
	typedef struct packed {
		logic [11:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} amot_bus_req_t;

	typedef struct packed {
		logic [11:0] core0;
		logic [11:0] core1;
		logic [11:0] core2_a;
		logic [11:0] core2_b;
	} amot_fuse_trim_t;

	typedef struct packed {
		logic offset_cal_enable;
		logic background_cal_enable;
		logic background_offset_cal_enable;
		logic foreground_cal_done;
		logic offset_cal_busy;
	} amot_cal_state_t;

endpackage : amot_pkg

// ==== tb_amot_regs.sv ====
// Self-checking bench for the alarm mask, lane fault and trim registers.
// Assumes amot_pkg and amot_regs are compiled before this file.
`timescale 1ns/1ps
module tb_amot_regs;
	import amot_pkg::*;
	logic            clk_sys;
	logic            resetn;
	amot_bus_req_t   bus_req;
	logic [15:0]     rd_data_q;
	logic [7:0]      lerr;
	logic [7:0]      lv;
	logic [5:0]      src;
	amot_fuse_trim_t fuse_trim;
	amot_cal_state_t cal_state;
	logic            sample_input_b;
	logic            alarm_irq_q;
	logic [11:0]     core0_offset_q;
	logic [11:0]     core1_offset_q;
	logic [11:0]     core2_offset_q;
	logic            spare_fg_offset_cal_q;
	logic            rd_p;
	logic [15:0]     exp_q[$];
	logic [11:0]     tv[4];
	logic [31:0]     seed;
	int              ks[5] = '{5, 4, 3, 2, 0};
	int              errors;
	int              n_tests;
	int              cyc;

	// Lane 0 doubles as the lane buffer fault source of the alarm loop.
	amot_regs amot_regs_inst (
		.clk_sys               (clk_sys),
		.resetn                (resetn),
		.bus_req               (bus_req),
		.rd_data_q             (rd_data_q),
		.lane_fifo_err         (lerr | {7'h00, src[5]}),
		.serdes_pll_unlock_flag(src[4]),
		.link_down_flag        (src[3]),
		.clock_realign_flag    (src[2]),
		.divider_mismatch_flag (src[0]),
		.fuse_trim             (fuse_trim),
		.cal_state             (cal_state),
		.sample_input_b        (sample_input_b),
		.alarm_irq_q           (alarm_irq_q),
		.core0_offset_q        (core0_offset_q),
		.core1_offset_q        (core1_offset_q),
		.core2_offset_q        (core2_offset_q),
		.spare_fg_offset_cal_q (spare_fg_offset_cal_q)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check

	task acc(input logic w, input logic r, input logic [11:0] a,
		input logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{a, d, w, r};
	endtask : acc

	task wr(input logic [11:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask : wr

	task rd(input logic [11:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		acc(1'b0, 1'b1, a, 16'h0000);
	endtask : rd

	task idle(input int n);
		repeat (n) acc(1'b0, 1'b0, 12'h000, 16'h0000);
	endtask : idle

	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ********************************************************
	// Read monitor and watchdog
	// ********************************************************
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rd_p <= 1'b0;
		else
			rd_p <= bus_req.rd;
	end

	// Read data stand only in the cycle after the strobe, so look there.
	always @(negedge clk_sys) begin
		if (rd_p)
			check(rd_data_q, exp_q.pop_front());
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		bus_req = '0;
		lerr = 8'h00;
		src = 6'h00;
		sample_input_b = 1'b0;
		cal_state = '0;
		fuse_trim = {12'h1A5, 12'h2B6, 12'h3C7, 12'h4D8};
		seed = 32'd46686;
		errors = 0;
		n_tests = 0;
		cyc = 0;
		resetn = 1'b0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(OFF_LANE_FAULTS, 16'h00FF);
		rd(OFF_ALARM_MASKS, 16'h003F);
		rd(OFF_CORE0_TRIM, 16'h01A5);
		rd(OFF_CORE2_B_TRIM, 16'h04D8);
		wr(12'h2C3, 16'h00FF);
		rd(12'h2C3, 16'h0000);
		idle(2);
		@(negedge clk_sys);
		check({4'h0, core1_offset_q}, 16'h02B6);
		check({15'h0000, alarm_irq_q}, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			tv[i] = seed[11:0];
			wr(OFF_CORE0_TRIM + 12'(2 * i), {4'h0, tv[i]});
			rd(OFF_CORE0_TRIM + 12'(2 * i), {4'h0, tv[i]});
		end
		idle(2);
		sample_input_b <= 1'b0;
		@(negedge clk_sys);
		check({4'h0, core0_offset_q}, {4'h0, tv[0]});
		check({4'h0, core1_offset_q}, {4'h0, tv[1]});
		check({4'h0, core2_offset_q}, {4'h0, tv[2]});
		idle(1);
		sample_input_b <= 1'b1;
		idle(2);
		@(negedge clk_sys);
		check({4'h0, core2_offset_q}, {4'h0, tv[3]});
		$display("test trims done");
		wr(OFF_ALARM_STATUS, 16'h003F);
		wr(OFF_LANE_FAULTS, 16'h00FF);
		rd(OFF_LANE_FAULTS, 16'h0000);
		seed = xs(seed);
		lv = seed[7:0] | 8'h01;
		lerr <= lv;
		idle(1);
		lerr <= 8'h00;
		rd(OFF_LANE_FAULTS, {8'h00, lv});
		rd(OFF_ALARM_STATUS, 16'h0020);
		wr(OFF_LANE_FAULTS, 16'h0001);
		rd(OFF_LANE_FAULTS, {8'h00, lv & 8'hFE});
		wr(OFF_LANE_FAULTS, 16'h0080);
		lerr <= 8'h80;
		idle(1);
		lerr <= 8'h00;
		rd(OFF_LANE_FAULTS, {8'h00, lv & 8'hFE | 8'h80});
		wr(OFF_ALARM_STATUS, 16'h0020);
		rd(OFF_LANE_FAULTS, 16'h0000);
		rd(OFF_ALARM_STATUS, 16'h0000);
		$display("test lanes done");
		for (int j = 0; j < 5; j++) begin
			wr(OFF_ALARM_MASKS, 16'h003F);
			wr(OFF_ALARM_STATUS, 16'h003F);
			src <= 6'(1 << ks[j]);
			idle(3);
			@(negedge clk_sys);
			check({15'h0000, alarm_irq_q}, 16'h0000);
			wr(OFF_ALARM_MASKS, 16'(8'h3F & ~(8'h01 << ks[j])));
			idle(3);
			@(negedge clk_sys);
			check({15'h0000, alarm_irq_q}, 16'h0001);
			rd(OFF_ALARM_SUMMARY, 16'h0001);
			rd(OFF_ALARM_STATUS, 16'(1 << ks[j]));
			src <= 6'h00;
			wr(OFF_ALARM_STATUS, 16'(1 << ks[j]));
			idle(3);
			@(negedge clk_sys);
			check({15'h0000, alarm_irq_q}, 16'h0000);
		end
		$display("test alarms done");
		idle(1);
		cal_state <= 5'b11001;
		idle(3);
		@(negedge clk_sys);
		check({15'h0000, spare_fg_offset_cal_q}, 16'h0001);
		rd(OFF_CAL_STATE, 16'h0002);
		idle(1);
		cal_state <= 5'b11000;
		idle(2);
		rd(OFF_CAL_STATE, 16'h0002);
		idle(1);
		cal_state <= 5'b11010;
		idle(2);
		rd(OFF_CAL_STATE, 16'h0003);
		wr(OFF_CORE1_TRIM, {4'h0, tv[0]});
		rd(OFF_CORE1_TRIM, {4'h0, tv[0]});
		idle(1);
		cal_state <= 5'b11100;
		idle(3);
		@(negedge clk_sys);
		check({15'h0000, spare_fg_offset_cal_q}, 16'h0000);
		rd(OFF_CAL_STATE, 16'h0000);
		idle(1);
		cal_state <= 5'b01000;
		idle(2);
		rd(OFF_CAL_STATE, 16'h0001);
		$display("test calibration done");
		idle(2);
		test_done();
	end
endmodule : tb_amot_regs
